// >>> rtl/maint_link_params.svh
// Constants for the card maintenance link slave
`ifndef MAINT_LINK_PARAMS_SVH
`define MAINT_LINK_PARAMS_SVH

`define ML_CLK_HZ        40000000
`define ML_BAUD_DEF      9600
`define ML_DATA_BITS     8
`define ML_SLOT_BITS     5
`define ML_FRAME_CH      32
`define ML_CH_BITS       10
`define ML_FRAME_HZ      8000
`define ML_PEND_FRAMES   5
`define ML_PREAMBLE      4'hE
`define ML_PREAMBLE_LEN  4
`define ML_MSG_BITS      8
`define ML_CMD_POLL      3'h0
`define ML_CMD_STATUS    3'h1
`define ML_CMD_ACK       3'h2
`define ML_REPLY_POLL    3'h0
`define ML_REPLY_STATUS  3'h1

`endif

// >>> rtl/maint_link_pkg.sv
// Types for the card maintenance link slave
package maint_link_pkg;
	typedef enum logic [1:0] {
		TS_IDLE = 2'b00,
		TS_ANN  = 2'b01,
		TS_WAIT = 2'b10,
		TS_SEND = 2'b11
	} slot_st_t;
	typedef enum logic [1:0] {
		LK_IDLE  = 2'b00,
		LK_ADDR  = 2'b01,
		LK_REPLY = 2'b10
	} link_st_t;
endpackage : maint_link_pkg

// >>> rtl/uart_char.sv
// Asynchronous character receiver and transmitter for the maintenance link
`timescale 1ns/100ps
`include "maint_link_params.svh"

module uart_char #(
	parameter int DIV   = `ML_CLK_HZ / `ML_BAUD_DEF,
	parameter int DBITS = `ML_DATA_BITS
) (
	input  wire logic             clk,
	input  wire logic             rst,
	input  wire logic             rxSync,   // Already synchronised line
	output logic [DBITS-1:0]      rxData,
	output logic                  rxValid,  // One-cycle pulse
	input  wire logic [DBITS-1:0] txData,
	input  wire logic             txStart,
	output logic                  txBusy,
	output logic                  txLine
);
	initial begin
		// Bit counters are 16 bits wide, so slower rates need a wider counter
		if (DIV < 4 || DIV > 65535 || DBITS < 5 || DBITS > 9) $error("uart_char: bad parameters");
	end

	// ----------------------------------------------------------------
	// Receiver
	// ----------------------------------------------------------------
	logic [15:0]      rxCnt_r;
	logic [3:0]       rxBit_r;
	logic             rxAct_r;
	logic [DBITS-1:0] rxSh_r;

	// Start found on falling line, sampled mid-bit; stop bit checked high
	always_ff @(posedge clk) begin
		rxValid <= 1'b0;
		if (rst) begin
			rxAct_r <= 1'b0;
			rxCnt_r <= 16'h0000;
			rxBit_r <= 4'h0;
			rxSh_r  <= '0;
			rxData  <= '0;
		end else if (!rxAct_r) begin
			if (!rxSync) begin
				rxAct_r <= 1'b1;
				rxCnt_r <= 16'(DIV / 2);
				rxBit_r <= 4'h0;
			end
		end else if (rxCnt_r != 16'h0000) begin
			rxCnt_r <= rxCnt_r - 16'h0001;
		end else begin
			rxCnt_r <= 16'(DIV - 1);
			rxBit_r <= rxBit_r + 4'h1;
			if (rxBit_r == 4'h0 && rxSync) begin
				rxAct_r <= 1'b0;        // Glitch, not a start bit
			end else if (rxBit_r == 4'(DBITS + 1)) begin
				rxAct_r <= 1'b0;
				if (rxSync) begin
					rxData  <= rxSh_r;
					rxValid <= 1'b1;
				end
			end else if (rxBit_r != 4'h0) begin
				rxSh_r <= {rxSync, rxSh_r[DBITS-1:1]};
			end
		end
	end

	// ----------------------------------------------------------------
	// Transmitter: start, data LSB first, one stop
	// ----------------------------------------------------------------
	logic [15:0]    txCnt_r;
	logic [3:0]     txBit_r;
	logic [DBITS:0] txSh_r;

	always_ff @(posedge clk) begin
		if (rst) begin
			txBusy  <= 1'b0;
			txLine  <= 1'b1;
			txCnt_r <= 16'h0000;
			txBit_r <= 4'h0;
			txSh_r  <= '1;
		end else if (!txBusy) begin
			if (txStart) begin
				txBusy  <= 1'b1;
				txLine  <= 1'b0;
				txSh_r  <= {1'b1, txData};
				txCnt_r <= 16'(DIV - 1);
				txBit_r <= 4'h0;
			end
		end else if (txCnt_r != 16'h0000) begin
			txCnt_r <= txCnt_r - 16'h0001;
		end else if (txBit_r == 4'(DBITS + 1)) begin
			txBusy <= 1'b0;
		end else begin
			txCnt_r <= 16'(DIV - 1);
			txBit_r <= txBit_r + 4'h1;
			txLine  <= txSh_r[0];
			txSh_r  <= {1'b1, txSh_r[DBITS:1]};
		end
	end
endmodule : uart_char

// >>> rtl/card_maintenance_link_slave.sv
// Maintenance serial link slave and frame slot zero message flag
// How it works
// - Status returns on separate input bus
// - Shared buses, controller master, cards slaves
// - Backplane slot address; answer only own
// - Poll reply carries slot, change flag
// - Slave never transmits unprompted
// - Self-test result flagged at next poll, returned on status command
// - Pending message: ones for five frames
// - Then preamble 1110 and message bits
// - Frame: 32 ten-bit channels at 8 kHz
`timescale 1ns/100ps
`include "maint_link_params.svh"

module card_maintenance_link_slave #(
	parameter int BAUD    = `ML_BAUD_DEF,
	parameter int MSGBITS = `ML_MSG_BITS
) (
	input  wire logic                     clk,
	input  wire logic                     rst,
	input  wire logic [`ML_SLOT_BITS-1:0] slotAddr,      // Backplane straps
	input  wire logic                     ctrlBusIn,     // Output bus from controller
	output logic                          statBusOut,    // Input bus to controller
	output logic                          statBusOe,     // Drive enable on shared bus
	input  wire logic                     selfTestDone,  // Local self-test finished
	input  wire logic                     selfTestPass,
	input  wire logic [7:0]               cardStatus,    // Status to report
	output logic [7:0]                    cfgData,       // Downloaded configuration
	output logic                          cfgStrobe,
	input  wire logic                     slotZeroIn,    // Frame slot zero bit from network
	input  wire logic                     slotZeroTick,  // Pulse at each slot zero
	output logic                          slotZeroOut,
	input  wire logic                     msgReq,        // Card has a message waiting
	input  wire logic [MSGBITS-1:0]       msgData,
	output logic                          msgDone
);
	localparam int DIV = `ML_CLK_HZ / BAUD;
	initial begin
		// Slot-zero counter is 8 bits and must hold the message plus its preamble
		if (DIV < 4 || MSGBITS < 1 || MSGBITS > 252) $error("card_maintenance_link_slave: bad parameters");
		// Frame figures kept for reference of the loop timing
		if (`ML_FRAME_CH * `ML_CH_BITS * `ML_FRAME_HZ != 2560000) $error("frame rate mismatch");
	end

	// ----------------------------------------------------------------
	// Pin synchronisers
	// ----------------------------------------------------------------
	logic [1:0] rxSy_r;
	logic [1:0] zSy_r;
	always_ff @(posedge clk) begin
		if (rst) begin
			rxSy_r <= 2'b11;
			zSy_r  <= 2'b00;
		end else begin
			rxSy_r <= {rxSy_r[0], ctrlBusIn};
			zSy_r  <= {zSy_r[0], slotZeroIn};
		end
	end

	// Straps caught once after reset release
	logic [`ML_SLOT_BITS-1:0] mySlot_r;
	logic                     slotCaught_r;
	always_ff @(posedge clk) begin
		if (rst) begin
			mySlot_r     <= '0;
			slotCaught_r <= 1'b0;
		end else if (!slotCaught_r) begin
			mySlot_r     <= slotAddr;
			slotCaught_r <= 1'b1;
		end
	end

	// ----------------------------------------------------------------
	// Character engine
	// ----------------------------------------------------------------
	logic [7:0] rxData;
	logic       rxValid;
	logic [7:0] txData_r;
	logic       txStart_r;
	logic       txBusy;
	logic       txLine;

	uart_char #(.DIV(DIV), .DBITS(`ML_DATA_BITS)) uChar (
		.clk     (clk),
		.rst     (rst),
		.rxSync  (rxSy_r[1]),
		.rxData  (rxData),
		.rxValid (rxValid),
		.txData  (txData_r),
		.txStart (txStart_r),
		.txBusy  (txBusy),
		.txLine  (txLine)
	);

	// ----------------------------------------------------------------
	// Link protocol: address byte {cmd[7:5], slot[4:0]}, then reply
	// ----------------------------------------------------------------
	maint_link_pkg::link_st_t lk_r;
	logic       changed_r;   // Status changed since last poll
	logic       stPending_r; // Self-test result not yet reported
	logic [7:0] lastStat_r;
	logic       cfgNext_r;   // Next byte is configuration data
	logic       sent_r;

	wire addrHit = rxValid && rxData[4:0] == mySlot_r && slotCaught_r;

	always_ff @(posedge clk) begin
		txStart_r <= 1'b0;
		cfgStrobe <= 1'b0;
		if (rst) begin
			lk_r      <= maint_link_pkg::LK_IDLE;
			txData_r  <= 8'h00;
			cfgData   <= 8'h00;
			cfgNext_r <= 1'b0;
			sent_r    <= 1'b0;
		end else begin
			unique case (lk_r)
				maint_link_pkg::LK_IDLE: begin
					if (rxValid && cfgNext_r) begin
						cfgData   <= rxData;  // Configuration download
						cfgStrobe <= 1'b1;
						cfgNext_r <= 1'b0;
					end else if (addrHit) begin
						// Replies only after a prompt to this slot
						if (rxData[7:5] == `ML_CMD_POLL) begin
							// Slot address, change and self-test flags
							txData_r <= {`ML_REPLY_POLL, mySlot_r};
							txData_r[7] <= changed_r | stPending_r;
							lk_r <= maint_link_pkg::LK_REPLY;
						end else if (rxData[7:5] == `ML_CMD_STATUS) begin
							txData_r <= stPending_r ? {7'h00, selfTestPass} : cardStatus;
							lk_r <= maint_link_pkg::LK_REPLY;
						end else begin
							cfgNext_r <= 1'b1;
						end
					end
				end
				maint_link_pkg::LK_REPLY: begin
					if (!sent_r) begin
						txStart_r <= 1'b1;
						sent_r    <= 1'b1;
					end else if (!txBusy && !txStart_r) begin
						sent_r <= 1'b0;
						lk_r   <= maint_link_pkg::LK_IDLE;
					end
				end
				default: lk_r <= maint_link_pkg::LK_IDLE;
			endcase
		end
	end

	// Change and self-test flags; new change wins over clear by poll
	wire pollHit = lk_r == maint_link_pkg::LK_IDLE && addrHit && !cfgNext_r;
	logic doneD_r;  // Self-test done one cycle late, for its rising edge
	always_ff @(posedge clk) begin
		if (rst) begin
			changed_r   <= 1'b0;
			stPending_r <= 1'b0;
			lastStat_r  <= 8'h00;
			doneD_r     <= 1'b0;
		end else begin
			lastStat_r <= cardStatus;
			doneD_r    <= selfTestDone;
			if (cardStatus != lastStat_r)
				changed_r <= 1'b1;
			else if (pollHit && rxData[7:5] == `ML_CMD_POLL)
				changed_r <= 1'b0;
			// Armed once per insertion by the rising edge; a level would re-arm after the query
			if (selfTestDone && !doneD_r)
				stPending_r <= 1'b1;
			else if (pollHit && rxData[7:5] == `ML_CMD_STATUS)
				stPending_r <= 1'b0;
		end
	end

	// Shared input bus driven only while replying
	always_comb begin
		statBusOe  = txBusy;
		statBusOut = txLine;
	end

	// ----------------------------------------------------------------
	// Frame slot zero message flag
	// ----------------------------------------------------------------
	maint_link_pkg::slot_st_t ts_r;
	logic [7:0]          zCnt_r;
	logic [MSGBITS+3:0]  zSh_r;
	wire                 tick = slotZeroTick;

	always_ff @(posedge clk) begin
		msgDone <= 1'b0;
		if (rst) begin
			ts_r        <= maint_link_pkg::TS_IDLE;
			zCnt_r      <= 8'h00;
			zSh_r       <= '0;
			slotZeroOut <= 1'b0;
		end else if (tick) begin
			unique case (ts_r)
				maint_link_pkg::TS_IDLE: begin
					slotZeroOut <= 1'b0;
					if (msgReq) begin
						ts_r        <= maint_link_pkg::TS_ANN;
						zCnt_r      <= 8'h01;
						slotZeroOut <= 1'b1;
					end
				end
				maint_link_pkg::TS_ANN: begin
					if (zCnt_r == 8'(`ML_PEND_FRAMES)) begin
						slotZeroOut <= 1'b0;
						ts_r        <= maint_link_pkg::TS_WAIT;
					end else begin
						zCnt_r <= zCnt_r + 8'h01;
					end
				end
				maint_link_pkg::TS_WAIT: begin
					if (zSy_r[1]) begin
						// Send enable seen; preamble then message
						zSh_r       <= {`ML_PREAMBLE, msgData};
						slotZeroOut <= 1'b1;
						zCnt_r      <= 8'(MSGBITS + `ML_PREAMBLE_LEN - 1);
						ts_r        <= maint_link_pkg::TS_SEND;
					end
				end
				maint_link_pkg::TS_SEND: begin
					if (zCnt_r == 8'h00) begin
						slotZeroOut <= 1'b0;
						msgDone     <= 1'b1;
						ts_r        <= maint_link_pkg::TS_IDLE;
					end else begin
						zSh_r       <= {zSh_r[MSGBITS+2:0], 1'b0};
						slotZeroOut <= zSh_r[MSGBITS+2];
						zCnt_r      <= zCnt_r - 8'h01;
					end
				end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	property p_quiet;
		@(posedge clk) disable iff (rst) statBusOe |-> lk_r == maint_link_pkg::LK_REPLY;
	endproperty
	a_quiet: assert property (p_quiet) else $error("bus driven unprompted");

	property p_reply;
		@(posedge clk) disable iff (rst) pollHit && rxData[7:5] == `ML_CMD_POLL |-> ##3 statBusOe;
	endproperty
	a_reply: assert property (p_reply) else $error("no reply to own poll");

	property p_foreign;
		@(posedge clk) disable iff (rst) rxValid && lk_r == maint_link_pkg::LK_IDLE && !cfgNext_r &&
			rxData[4:0] != mySlot_r |=> lk_r == maint_link_pkg::LK_IDLE;
	endproperty
	a_foreign: assert property (p_foreign) else $error("answered foreign slot");

	property p_slot;
		@(posedge clk) disable iff (rst) (pollHit && rxData[7:5] == `ML_CMD_POLL) |=> txData_r[4:0] == mySlot_r;
	endproperty
	a_slot: assert property (p_slot) else $error("reply lacks slot");

	property p_ann;
		@(posedge clk) disable iff (rst) tick && ts_r == maint_link_pkg::TS_IDLE && msgReq |=> slotZeroOut;
	endproperty
	a_ann: assert property (p_ann) else $error("no ones on pending");

	property p_annEnd;
		@(posedge clk) disable iff (rst) tick && ts_r == maint_link_pkg::TS_ANN && zCnt_r == 8'h05 |=>
			!slotZeroOut && ts_r == maint_link_pkg::TS_WAIT;
	endproperty
	a_annEnd: assert property (p_annEnd) else $error("ones run not five");

	property p_pre;
		@(posedge clk) disable iff (rst) tick && ts_r == maint_link_pkg::TS_WAIT && zSy_r[1] |=> slotZeroOut;
	endproperty
	a_pre: assert property (p_pre) else $error("preamble not started");

	property p_stReport;
		@(posedge clk) disable iff (rst) stPending_r && pollHit && rxData[7:5] == `ML_CMD_POLL |=> txData_r[7];
	endproperty
	a_stReport: assert property (p_stReport) else $error("self-test not flagged");

	c_poll: cover property (@(posedge clk) pollHit);
	c_cfg:  cover property (@(posedge clk) cfgStrobe);
	c_msg:  cover property (@(posedge clk) msgDone);
endmodule : card_maintenance_link_slave

// >>> tb/ctrl_model.sv
// Controller model acting as master of the maintenance serial link
`timescale 1ns/100ps

module ctrl_model #(
	parameter int DIV = 10
) (
	input  wire logic clk,
	output logic       ctrlLine,  // Control bus toward the card, idle high
	input  wire logic  statLine,  // Resolved status bus, pulled up when released
	output logic [7:0] rxByte,    // Last reply character
	output logic       rxPulse    // One cycle per reply received
);
	// ----------------------------------------
	// Idle state
	// ----------------------------------------
	initial begin
		ctrlLine = 1'b1;
		rxPulse  = 1'b0;
		rxByte   = 8'h00;
	end

	// Start bit, eight data bits LSB first, one stop bit
	task automatic send_byte(input logic [7:0] b);
		logic [9:0] fr;
		fr = {1'b1, b, 1'b0};
		for (int i = 0; i < 10; i++) begin
			@(negedge clk) ctrlLine = fr[i];
			repeat (DIV - 1) @(negedge clk);
		end
	endtask : send_byte

	// Waits a bounded time for a reply; the bus is never driven here
	task automatic recv_byte(input int lim, output logic got);
		int n;
		n   = 0;
		got = 1'b0;
		while (statLine !== 1'b0 && n < lim) begin
			@(negedge clk);
			n++;
		end
		if (statLine === 1'b0) begin
			repeat (DIV / 2) @(negedge clk);
			for (int i = 0; i < 8; i++) begin
				repeat (DIV) @(negedge clk);
				rxByte[i] = statLine;
			end
			// Let the stop bit and the drive enable run out
			repeat (2 * DIV) @(negedge clk);
			got     = 1'b1;
			rxPulse = 1'b1;
			@(negedge clk) rxPulse = 1'b0;
		end
	endtask : recv_byte
endmodule : ctrl_model

// >>> tb/tb_top.sv
// Self-checking bench for the maintenance link slave
`timescale 1ns/100ps

module tb_top;
	// ----------------------------------------
	// Signals
	// ----------------------------------------
	logic        clk = 1'b0, rst = 1'b1;
	logic [4:0]  slotAddr;
	logic        ctrlLine, statBusOut, statBusOe, statLine;
	logic        selfTestDone = 1'b0, selfTestPass = 1'b1;
	logic [7:0]  cardStatus, cfgData, rxByte, msgData;
	logic        cfgStrobe, rxPulse, msgDone;
	logic        slotZeroIn = 1'b0, slotZeroTick = 1'b0, slotZeroOut, msgReq = 1'b0;
	logic [7:0]  expQ[$];          // Expected replies and configuration bytes
	logic [7:0]  rnd = 8'h53;      // Random source, fixed start
	int          err_count = 0, n_tests = 0, cyc = 0;
	logic [7:0]  oeRise = 8'h00, doneCnt = 8'h00;
	logic        oeD = 1'b0;

	always #12.5 clk = ~clk;
	// Released bus floats up through the backplane pull-up
	assign statLine = statBusOe ? statBusOut : 1'b1;

	card_maintenance_link_slave #(.BAUD(4000000)) uut (
		.clk(clk), .rst(rst), .slotAddr(slotAddr), .ctrlBusIn(ctrlLine),
		.statBusOut(statBusOut), .statBusOe(statBusOe), .selfTestDone(selfTestDone),
		.selfTestPass(selfTestPass), .cardStatus(cardStatus), .cfgData(cfgData),
		.cfgStrobe(cfgStrobe), .slotZeroIn(slotZeroIn), .slotZeroTick(slotZeroTick),
		.slotZeroOut(slotZeroOut), .msgReq(msgReq), .msgData(msgData), .msgDone(msgDone));

	ctrl_model #(.DIV(10)) ctl (
		.clk(clk), .ctrlLine(ctrlLine), .statLine(statLine), .rxByte(rxByte), .rxPulse(rxPulse));

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	function automatic logic [7:0] lfsr(input logic [7:0] s);
		return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
	endfunction : lfsr

	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		n_tests++;
		if (seen !== exp) begin
			err_count++;
			$display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check

	task automatic end_sim();
		$display("Comparisons %0d, mismatches %0d", n_tests, err_count);
		if (err_count == 0 && n_tests > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : end_sim

	// One command byte and its awaited reply, if any
	task automatic xact(input logic [2:0] cmd, input logic [4:0] sl, input logic [7:0] ev, input logic want);
		logic got;
		if (want)
			expQ.push_back(ev);
		ctl.send_byte({cmd, sl});
		ctl.recv_byte(400, got);
		check({15'h0000, got}, {15'h0000, want});
	endtask : xact

	// Network slot-zero tick, then sample our bit once it has settled
	task automatic tick_samp(output logic v);
		@(negedge clk) slotZeroTick = 1'b1;
		@(negedge clk) slotZeroTick = 1'b0;
		repeat (3) @(negedge clk);
		v = slotZeroOut;
		repeat (10) @(negedge clk);
	endtask : tick_samp

	// ----------------------------------------
	// Watchers: replies, strobes, drive enables
	// ----------------------------------------
	always @(posedge clk) begin
		cyc++;
		oeD <= statBusOe;
		if (statBusOe === 1'b1 && oeD === 1'b0)
			oeRise <= oeRise + 8'h01;
		if (msgDone === 1'b1)
			doneCnt <= doneCnt + 8'h01;
		if (rxPulse === 1'b1 || cfgStrobe === 1'b1) begin
			if (expQ.size() == 0)
				check(16'hFFFF, 16'h0000);
			else
				check({8'h00, (cfgStrobe === 1'b1) ? cfgData : rxByte}, {8'h00, expQ.pop_front()});
		end
		if (cyc == 20000) begin
			err_count++;
			end_sim();
		end
	end

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		logic       v;
		logic [7:0] ones;
		logic [11:0] sh;
		rnd = lfsr(rnd);
		slotAddr = rnd[4:0];
		rnd = lfsr(rnd);
		cardStatus = rnd;
		msgData = 8'h00;
		repeat (3) @(negedge clk);
		rst = 1'b0;
		repeat (5) @(negedge clk);
		selfTestDone = 1'b1;
		repeat (4) @(negedge clk);
		// Polling round: a neighbour slot first, then ours
		xact(3'h0, slotAddr + 5'h01, 8'h00, 1'b0);
		xact(3'h0, slotAddr, {1'b1, 2'b00, slotAddr}, 1'b1);
		xact(3'h1, slotAddr, 8'h01, 1'b1);
		xact(3'h0, slotAddr, {1'b0, 2'b00, slotAddr}, 1'b1);
		xact(3'h1, slotAddr, cardStatus, 1'b1);
		rnd = lfsr(rnd);
		cardStatus = ~cardStatus;
		repeat (4) @(negedge clk);
		xact(3'h0, slotAddr, {1'b1, 2'b00, slotAddr}, 1'b1);
		// Configuration download: command then one data byte
		expQ.push_back(rnd);
		ctl.send_byte({3'h2, slotAddr});
		ctl.send_byte(rnd);
		repeat (40) @(negedge clk);
		check({8'h00, oeRise}, 16'h0005);
		// Slot-zero message flag
		rnd = lfsr(rnd);
		msgData = rnd;
		msgReq = 1'b1;
		ones = 8'h00;
		v = 1'b1;
		for (int i = 0; i < 8 && v === 1'b1; i++) begin
			tick_samp(v);
			if (v === 1'b1)
				ones = ones + 8'h01;
		end
		check({8'h00, ones}, 16'h0005);
		slotZeroIn = 1'b1;
		repeat (4) @(negedge clk);
		tick_samp(v);
		slotZeroIn = 1'b0;
		for (int i = 0; i < 3 && v !== 1'b1; i++)
			tick_samp(v);
		sh = {11'h000, v};
		for (int i = 0; i < 11; i++) begin
			tick_samp(v);
			sh = {sh[10:0], v};
		end
		check({4'h0, sh}, {4'h0, 4'hE, msgData});
		tick_samp(v);
		msgReq = 1'b0;
		check({8'h00, doneCnt}, 16'h0001);
		check({15'h0000, v}, 16'h0000);
		repeat (20) @(negedge clk);
		check({8'h00, 7'h00, expQ.size() == 0}, 16'h0001);
		end_sim();
	end
endmodule : tb_top
